// ---- dv/mfd_decode_monitor.sv ----
// Purpose: Port checks on the decoder
// Assumes: clk_en held high
// Notes:   Bound at the foot
`timescale 1ns/1ps
`default_nettype none
module mfd_decode_monitor
(
	// Watched
	input wire logic               sys_clk,
	input wire logic               rst_n,
	input wire logic               cycle_end,
	input wire logic [2:0]         bit_sel,
	input wire logic [7:0]         bit_mask,
	input wire mfd_pkg::mfd_byte_t file_rdata,
	input wire logic               file_we,
	input wire mfd_pkg::mfd_byte_t file_wdata,
	input wire mfd_pkg::mfd_byte_t acc_out,
	input wire logic               carry_out,
	input wire logic [12:0]        stack_head,
	input wire logic               stack_pop,
	input wire logic [12:0]        pc_value,
	input wire logic               flush_nop
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence gap_s; !cycle_end[*3] ##1 cycle_end; endsequence
	sequence fl_s; flush_nop[*4] ##1 !flush_nop; endsequence
	cycle_len_a: assert property (cycle_end |=> gap_s)
		else $error("cycle length");
	bit_mask_a: assert property (bit_mask == (8'h01 << bit_sel))
		else $error("bit mask");
	write_time_a: assert property (file_we |-> $past(cycle_end))
		else $error("write time");
	rot_data_a: assert property (file_we |->
		file_wdata[7:1] == $past(file_rdata[6:0]) &&
		carry_out == $past(file_rdata[7])) else $error("rotate");
	pop_pc_a: assert property (stack_pop |->
		pc_value == $past(stack_head)) else $error("pc load");
	flush_a: assert property (stack_pop |-> fl_s)
		else $error("flush length");
	acc_time_a: assert property ($changed(acc_out) |->
		$past(cycle_end)) else $error("acc time");
	carry_time_a: assert property ($changed(carry_out) |->
		$past(cycle_end)) else $error("carry time");
endmodule
bind mfd_decode mfd_decode_monitor u_mon (.*);
`default_nettype wire

// ---- dv/mfd_regfile_model.sv ----
// Purpose: Register file and stack head beside the decoder
// Assumes: Combinational read of file_addr
// Notes:   Only the top address is preset; others read unknown
`timescale 1ns/1ps
`default_nettype none
module mfd_regfile_model
#(
	parameter logic [12:0] RET_ADDR = 13'h0123,
	parameter logic [7:0]  PRESET   = 8'he6
)
(
	// Clock
	input  wire logic       sys_clk,
	// Register file
	input  wire logic [6:0] file_addr,
	input  wire logic       file_we,
	input  wire logic [7:0] file_wdata,
	output logic [7:0]      file_rdata,
	// Stack
	output logic [12:0]     stack_head
);
	logic [7:0] mem [128];
	initial mem[7'h7f] = PRESET;
	assign file_rdata = mem[file_addr];
	assign stack_head = RET_ADDR;
	always @(posedge sys_clk)
		if (file_we)
			mem[file_addr] <= file_wdata;
endmodule
`default_nettype wire

// ---- dv/test_mcu_instruction_field_decode.sv ----
// Purpose: Self-checking bench for the decoder
// Assumes: Words set one cycle before the latching Q4 edge
// Notes:   Words in flushed slots must leave no trace
`timescale 1ns/1ps
`default_nettype none
module test_mcu_instruction_field_decode;
	import mfd_pkg::*;
	localparam logic [7:0]  PRE = 8'he6;
	localparam logic [12:0] RET = 13'h0123;
	logic       sys_clk = 0, rst_n = 0, clk_en = 1;
	mfd_word_t  instr_word = 0;
	logic       instr_take, file_we, carry_out, stack_pop, pc_load;
	logic       cycle_end, flush_nop;
	logic [6:0] file_addr;
	logic [2:0] bit_sel;
	logic [7:0] bit_mask;
	mfd_byte_t  file_rdata, file_wdata, acc_out;
	logic [12:0] stack_head, pc_value;
	int         num_errors = 0, samples_checked = 0, ticks = 0;
	mfd_decode dut (.*);
	mfd_regfile_model #(.RET_ADDR(RET), .PRESET(PRE)) u_model (.*);
	initial forever #25 sys_clk = ~sys_clk;
	// Hang guard, well above the 44 cycles needed
	always @(posedge sys_clk)
		if (++ticks == 400)
		begin
			num_errors++;
			close_out();
		end
	task automatic chk(string n, logic [12:0] e, logic [12:0] g);
		samples_checked++;
		if (g !== e)
		begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	// Word w runs; nx sits in the slot after it; returns one cycle past
	task automatic run(mfd_word_t w, mfd_word_t nx);
		do @(posedge sys_clk) #1; while (cycle_end !== 1'b1);
		instr_word = w;
		do @(posedge sys_clk) #1; while (cycle_end !== 1'b1);
		instr_word = nx;
		@(posedge sys_clk) #1;
	endtask
	task automatic t_rot_acc;
		run(14'h0d7f, 14'h0000);
		chk("acc", {PRE[6:0], 1'b0}, acc_out);
		chk("take", 0, instr_take);
		chk("carry", PRE[7], carry_out);
		chk("we", 0, file_we);
	endtask
	task automatic t_rot_file;
		run(14'h0dff, 14'h0000);
		chk("we", 1, file_we);
		// Carry left set by the rotate before enters bit zero
		chk("wdata", {PRE[6:0], PRE[7]}, file_wdata);
		chk("acc", {PRE[6:0], 1'b0}, acc_out);
	endtask
	// Literal 0 and 255, with the ignored bits clear and then set
	task automatic t_ret;
		for (int i = 0; i < 2; i++)
		begin
			run({4'hd, {2{i[0]}}, {8{i[0]}}}, 14'h0d7f);
			chk("acc", {8{i[0]}}, acc_out);
			chk("pop", 1, stack_pop & pc_load);
			chk("pc", RET, pc_value);
			chk("flush", 1, flush_nop);
			repeat (4) @(posedge sys_clk) #1;
			chk("unflush", 0, flush_nop);
			chk("flushed", {8{i[0]}}, acc_out);
			chk("carry", PRE[7], carry_out);
		end
	endtask
	task automatic close_out;
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		repeat (4) @(posedge sys_clk);
		#1 rst_n = 1;
		t_rot_acc();
		t_rot_file();
		t_ret();
		close_out();
	end
endmodule
`default_nettype wire

// ---- hw/mfd_cfg.svh ----
// Purpose: Constants for the instruction field decoder
// Assumes: 14-bit program words, 8-bit data path
// Notes:   Timing counts are in oscillator periods of sys_clk
`ifndef MFD_CFG_SVH
`define MFD_CFG_SVH
`define MFD_WORD_W        14
`define MFD_FILE_MSB      6
`define MFD_DEST_BIT      7
`define MFD_BIT_LSB       7
`define MFD_BIT_MSB       9
`define MFD_LIT_MSB       7
`define MFD_RETLIT_OP     4'hd
`define MFD_RLC_OP        6'h0d
`define MFD_OSC_PER_CYCLE 3'h4
`define MFD_PC_W          13
`endif

// ---- hw/mfd_decode.sv ----
// Purpose: Field decode and execution timing for 14-bit instructions
// Assumes: Operand byte is read from the register file before Q4
// Notes:   Only return_with_literal and rotate_left_via_carry execute
// How it works
// RULE_01: The file address field is a seven-bit index from 0x00 to 0x7F.
// RULE_02: The bit field picks one bit of the addressed eight-bit register.
// RULE_03: Destination zero writes the accumulator, one writes the file.
// RULE_04: Don't-care opcode bits are never looked at by the decoder.
// RULE_05: An instruction takes one cycle, or two when it changes the PC.
// RULE_06: One instruction cycle is exactly four oscillator periods.
// RULE_07: Program code never uses reserved opcodes; they act as no-ops here.
// RULE_08: return_with_literal loads the literal to W and pops the stack head.
// RULE_09: rotate_left_via_carry updates only the carry flag.
// RULE_10: The rotate shifts left with old carry in and old bit seven out.
// RULE_11: Each instruction is one fourteen-bit word of opcode and operands.
// RULE_12: return_with_literal is followed by one forced no-op cycle.
`timescale 1ns/1ps
`default_nettype none
`include "mfd_cfg.svh"
module mfd_decode
(
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              rst_n,
	input  wire logic              clk_en,
	// Program memory
	input  wire mfd_pkg::mfd_word_t instr_word,
	output logic                   instr_take,
	// Register file
	output logic [6:0]             file_addr,
	output logic [2:0]             bit_sel,
	output logic [7:0]             bit_mask,
	input  wire mfd_pkg::mfd_byte_t file_rdata,
	output logic                   file_we,
	output mfd_pkg::mfd_byte_t     file_wdata,
	// Accumulator and carry
	output mfd_pkg::mfd_byte_t     acc_out,
	output logic                   carry_out,
	// Stack and program counter
	input  wire logic [12:0]       stack_head,
	output logic                   stack_pop,
	output logic                   pc_load,
	output logic [12:0]            pc_value,
	// Timing
	output logic                   cycle_end,
	output logic                   flush_nop
);
	import mfd_pkg::*;
	mfd_phase_e phase;
	mfd_word_t  ir_reg;
	mfd_byte_t  acc_reg;
	logic       carry_reg;
	logic       flush_reg;
	logic       we_reg;
	mfd_byte_t  wdata_reg;
	logic       pop_reg;
	logic [12:0] pcv_reg;
	function automatic logic [7:0] onehot3(input logic [2:0] n);
		onehot3 = 8'h01 << n;
	endfunction
	mfd_phase_gen u_phase
	(
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.clk_en    (clk_en),
		.phase     (phase),
		.cycle_end (cycle_end)
	);
	// Opcode matches look only at defined bits, so x bits never steer
	wire        is_retlit = ir_reg[13:10] == `MFD_RETLIT_OP;      // RULE_04
	wire        is_rlc    = ir_reg[13:8] == `MFD_RLC_OP;           // RULE_11
	wire        dest_file = ir_reg[`MFD_DEST_BIT];
	wire [7:0]  literal   = ir_reg[`MFD_LIT_MSB:0];
	wire [7:0]  rot_val   = {file_rdata[6:0], carry_reg};          // RULE_10
	wire        rot_cout  = file_rdata[7];                         // RULE_10
	wire        exec      = cycle_end && !flush_reg;
	// Unassigned opcodes fall through here and change nothing
	wire        do_rlc    = exec && is_rlc;                        // RULE_07
	wire        do_ret    = exec && is_retlit;
	assign file_addr  = ir_reg[`MFD_FILE_MSB:0];                   // RULE_01
	assign bit_sel    = ir_reg[`MFD_BIT_MSB:`MFD_BIT_LSB];
	assign bit_mask   = onehot3(bit_sel);                          // RULE_02
	assign instr_take = cycle_end;
	assign acc_out    = acc_reg;
	assign carry_out  = carry_reg;
	assign flush_nop  = flush_reg;
	assign file_we    = we_reg;
	assign file_wdata = wdata_reg;
	assign stack_pop  = pop_reg;
	assign pc_load    = pop_reg;
	assign pc_value   = pcv_reg;
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			ir_reg <= 14'h0000;
		else if (cycle_end)
			ir_reg <= instr_word;
	end
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			acc_reg   <= 8'h00;
			carry_reg <= 1'b0;
		end
		else if (do_ret)
			acc_reg <= literal; // RULE_08
		else if (do_rlc)
		begin
			carry_reg <= rot_cout; // RULE_09
			if (!dest_file)
				acc_reg <= rot_val; // RULE_03
		end
	end
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			we_reg    <= 1'b0;
			wdata_reg <= 8'h00;
		end
		else if (clk_en)
		begin
			we_reg <= do_rlc && dest_file; // RULE_03
			if (do_rlc)
				wdata_reg <= rot_val;
		end
	end
	// Pop strobe and PC load last one oscillator period
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			pop_reg <= 1'b0;
			pcv_reg <= 13'h0000;
		end
		else if (clk_en)
		begin
			pop_reg <= do_ret; // RULE_08
			if (do_ret)
				pcv_reg <= stack_head;
		end
	end
	// The fetched word after a PC change is stale, so its cycle is a no-op
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			flush_reg <= 1'b0;
		else if (cycle_end)
			flush_reg <= !flush_reg && is_retlit; // RULE_05 RULE_12
	end
endmodule
`default_nettype wire

// ---- hw/mfd_phase_gen.sv ----
// Purpose: Four-phase instruction cycle generator
// Assumes: One oscillator period per enabled sys_clk edge
// Notes:   cycle_end pulses in the last phase of each cycle
`timescale 1ns/1ps
`default_nettype none
`include "mfd_cfg.svh"
module mfd_phase_gen
(
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              rst_n,
	input  wire logic              clk_en,
	// Phase
	output mfd_pkg::mfd_phase_e    phase,
	output logic                   cycle_end
);
	import mfd_pkg::*;
	mfd_phase_e phase_reg;
	mfd_phase_e phase_next;
	always_comb
	begin
		case (phase_reg)
		MFD_Q1:  phase_next = MFD_Q2;
		MFD_Q2:  phase_next = MFD_Q3;
		MFD_Q3:  phase_next = MFD_Q4;
		MFD_Q4:  phase_next = MFD_Q1;
		default: phase_next = MFD_Q1;
		endcase
	end
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			phase_reg <= MFD_Q1;
		else if (clk_en)
			phase_reg <= phase_next; // RULE_06
	end
	assign phase     = phase_reg;
	assign cycle_end = clk_en && (phase_reg == MFD_Q4);
endmodule
`default_nettype wire

// ---- hw/mfd_pkg.sv ----
// Purpose: Types for the instruction field decoder
// Assumes: Used together with mfd_cfg.svh
// Notes:   Phase states are one-hot
package mfd_pkg;
	typedef enum logic [3:0] {
		MFD_Q1 = 4'h1,
		MFD_Q2 = 4'h2,
		MFD_Q3 = 4'h4,
		MFD_Q4 = 4'h8
	} mfd_phase_e;
	typedef logic [13:0] mfd_word_t;
	typedef logic [7:0]  mfd_byte_t;
endpackage
